// *** include/rds_sync_pkg.sv ***
`default_nettype none
package rds_sync_pkg;
  // ==========================================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] FLY_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] LAST_OFS   = 8'h0c;
  localparam logic [7:0] PREV_OFS   = 8'h10;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // status register bit positions
  localparam int STAT_SYNC_BIT   = 0;
  localparam int STAT_OVF_BIT    = 1;
  localparam int STAT_DAV_BIT    = 2;
  localparam int STAT_ERRCNT_LSB = 3;
  // ==========================================================================
  // flywheel maximum: reset value and the two special settings
  localparam logic [5:0] FLY_MAX_RST = 6'h20;
  localparam logic [5:0] FLY_OFF     = 6'h00;
  localparam logic [5:0] FLY_ENDLESS = 6'h3f;
  // ==========================================================================
  // block code: 26 bits, generator x^10+x^8+x^7+x^5+x^4+x^3+1
  localparam logic [4:0]  BLOCK_LAST_BIT = 5'h19;
  localparam logic [10:0] GEN_POLY       = 11'h5b9;
  localparam logic [9:0]  OFS_A          = 10'h0fc;
  localparam logic [9:0]  OFS_B          = 10'h198;
  localparam logic [9:0]  OFS_C          = 10'h168;
  localparam logic [9:0]  OFS_CP         = 10'h350;
  localparam logic [9:0]  OFS_D          = 10'h1b4;
  localparam logic [9:0]  OFS_E          = 10'h000;
  // longest correctable burst per situation
  localparam logic [2:0] BURST_LOCKED = 3'h5;
  localparam logic [2:0] BURST_MODE_A = 3'h0;
  localparam logic [2:0] BURST_MODE_B = 3'h2;
  localparam logic [2:0] BURST_MODE_C = 3'h5;
  // search correction select codes
  localparam logic [1:0] SEARCH_CORRECT_MODE_A = 2'h0;
  localparam logic [1:0] SEARCH_CORRECT_MODE_B = 2'h1;
  localparam logic [1:0] SEARCH_CORRECT_MODE_C = 2'h2;
  // data-available modes
  localparam logic [1:0] AVAIL_MODE_STANDARD    = 2'h0;
  localparam logic [1:0] AVAIL_MODE_FAST_SEARCH = 2'h1;
  localparam logic [1:0] AVAIL_MODE_REDUCED     = 2'h2;
  // block identification codes
  localparam logic [2:0] ID_A         = 3'h0;
  localparam logic [2:0] ID_B         = 3'h1;
  localparam logic [2:0] ID_C         = 3'h2;
  localparam logic [2:0] ID_D         = 3'h3;
  localparam logic [2:0] ID_CP        = 3'h4;
  localparam logic [2:0] ID_E_VALID   = 3'h5;
  localparam logic [2:0] ID_E_INVALID = 3'h6;
  localparam logic [2:0] ID_NONE      = 3'h7;
  // correction status codes
  localparam logic [1:0] ST_CLEAN     = 2'h0;
  localparam logic [1:0] ST_CORRECTED = 2'h1;
  localparam logic [1:0] ST_UNCORR    = 2'h2;
  // ==========================================================================
  // timing
  localparam int CLK_HZ       = 25000000;
  localparam int DAV_HOLD_MS  = 10;
  localparam int DAV_HOLD_CYC = CLK_HZ / 1000 * DAV_HOLD_MS;
  // ==========================================================================
  // types
  typedef struct packed {
    logic [15:0] data;
    logic [2:0]  block_ident_field;
    logic [1:0]  status;
  } blk_slot_t;
  typedef struct packed {
    logic [1:0] avail_mode;
    logic       search_correct_sel_hi;
    logic       search_correct_sel_lo;
    logic       rbds_mode;
    logic       restart_sync_bit;
  } ctrl_t;
  typedef enum logic [1:0] {PH_HUNT, PH_SECOND, PH_LOCKED} phase_t;
  typedef enum logic [1:0] {EV_IDLE, EV_LATE, EV_CORR} eng_t;
endpackage
`default_nettype wire

// *** src/rds_block_sync_decoder.sv ***
`default_nettype none
module rds_block_sync_decoder #(
  parameter int unsigned DAV_HOLD_CYC = rds_sync_pkg::DAV_HOLD_CYC
) (
  // system
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // demodulated bit stream
  input  wire logic        recovered_bit_clock,
  input  wire logic        recovered_bit_data,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // controller handshake
  output logic             data_ready_n
);
  localparam int HOLD_W = $clog2(DAV_HOLD_CYC + 1);

  if (DAV_HOLD_CYC < 2) begin : g_bad_hold
    $error("DAV_HOLD_CYC must be at least 2");
  end

  // ==========================================================================
  // code helpers
  function automatic logic [9:0] remainder(input logic [25:0] w);
    logic [9:0] r;
    r = '0;
    for (int i = 25; i >= 0; i--) begin
      if (r[9]) begin
        r = {r[8:0], w[i]} ^ rds_sync_pkg::GEN_POLY[9:0];
      end else begin
        r = {r[8:0], w[i]};
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] match_id(input logic [9:0] s, input logic rbds);
    case (s)
      rds_sync_pkg::OFS_A:  return rds_sync_pkg::ID_A;
      rds_sync_pkg::OFS_B:  return rds_sync_pkg::ID_B;
      rds_sync_pkg::OFS_C:  return rds_sync_pkg::ID_C;
      rds_sync_pkg::OFS_CP: return rds_sync_pkg::ID_CP;
      rds_sync_pkg::OFS_D:  return rds_sync_pkg::ID_D;
      rds_sync_pkg::OFS_E:  return rbds ? rds_sync_pkg::ID_E_VALID
                                        : rds_sync_pkg::ID_E_INVALID;
      default:              return rds_sync_pkg::ID_NONE;
    endcase
  endfunction

  function automatic logic [9:0] offset_of(input logic [2:0] id);
    case (id)
      rds_sync_pkg::ID_A:  return rds_sync_pkg::OFS_A;
      rds_sync_pkg::ID_B:  return rds_sync_pkg::OFS_B;
      rds_sync_pkg::ID_C:  return rds_sync_pkg::OFS_C;
      rds_sync_pkg::ID_CP: return rds_sync_pkg::OFS_CP;
      rds_sync_pkg::ID_D:  return rds_sync_pkg::OFS_D;
      default:             return rds_sync_pkg::OFS_E;
    endcase
  endfunction

  function automatic logic [2:0] next_id(input logic [2:0] id);
    case (id)
      rds_sync_pkg::ID_A:       return rds_sync_pkg::ID_B;
      rds_sync_pkg::ID_B:       return rds_sync_pkg::ID_C;
      rds_sync_pkg::ID_C:       return rds_sync_pkg::ID_D;
      rds_sync_pkg::ID_CP:      return rds_sync_pkg::ID_D;
      rds_sync_pkg::ID_E_VALID: return rds_sync_pkg::ID_E_VALID;
      default:                  return rds_sync_pkg::ID_A;
    endcase
  endfunction

  // multiply by x^-1 modulo the generator (constant term is one)
  function automatic logic [9:0] div_x(input logic [9:0] t);
    logic [10:0] v;
    v = {1'b0, t};
    if (t[0]) begin
      v = v ^ rds_sync_pkg::GEN_POLY;
    end
    return v[10:1];
  endfunction

  function automatic logic [2:0] top_bit(input logic [4:0] b);
    logic [2:0] k;
    k = '0;
    for (int i = 0; i < 5; i++) begin
      if (b[i]) k = 3'(i);
    end
    return k;
  endfunction

  function automatic logic [2:0] low_bit(input logic [4:0] b);
    logic [2:0] k;
    k = '0;
    for (int i = 4; i >= 0; i--) begin
      if (b[i]) k = 3'(i);
    end
    return k;
  endfunction

  // ==========================================================================
  // state
  logic                      bclk_s1_r, bclk_s2_r, bclk_s3_r;
  logic                      data_s1_r, data_s2_r;
  logic                      check_r;
  logic [25:0]               sr_r, sr_prev_r, work_r;
  logic [4:0]                bit_cnt_r, pos_r;
  logic [9:0]                t_r;
  logic [2:0]                limit_r, last_id_r;
  rds_sync_pkg::phase_t      phase_r;
  rds_sync_pkg::eng_t        eng_r;
  logic                      res_stb_r, res_ok_r;
  rds_sync_pkg::blk_slot_t   res_slot_r, evt_slot_r, last_slot_r, prev_slot_r;
  logic                      evt_blk_r, evt_dav_r, evt_locked_r, pair_r;
  logic [5:0]                err_cnt_r, fly_max_r;
  rds_sync_pkg::ctrl_t       ctrl_r;
  logic                      overflow_flag_r, data_ready_n_r;
  logic [HOLD_W-1:0]         dav_cnt_r;
  logic                      wr_pend_r, hreadyout_r;
  logic [7:0]                addr_r;
  logic [31:0]               hrdata_r, rd_word;

  logic       strobe, boundary, locked, ap, rd_status, rd_last;
  logic [2:0] id_now, id_prev, exp_id, t_top, t_low, t_span, mode_limit;
  logic       fit_now, fit_prev, trapped;
  logic [25:0] err_mask;

  // ==========================================================================
  // bit clock edge finder; first stages feed only the second
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      bclk_s3_r <= 1'b0;
      data_s1_r <= 1'b0;
      data_s2_r <= 1'b0;
    end else begin
      bclk_s1_r <= recovered_bit_clock;
      bclk_s2_r <= bclk_s1_r;
      bclk_s3_r <= bclk_s2_r;
      data_s1_r <= recovered_bit_data;
      data_s2_r <= data_s1_r;
    end
  end
  assign strobe = bclk_s2_r & ~bclk_s3_r;

  // block shift register; check_r marks the cycle the new window is evaluated
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sr_r      <= '0;
      sr_prev_r <= '0;
      check_r   <= 1'b0;
    end else begin
      check_r <= strobe;
      if (strobe) begin
        sr_prev_r <= sr_r;
        sr_r      <= {sr_r[24:0], data_s2_r};
      end
    end
  end

  // syndrome decode of the current and the one-bit-earlier windows
  assign id_now     = match_id(remainder(sr_r), ctrl_r.rbds_mode);
  assign id_prev    = match_id(remainder(sr_prev_r), ctrl_r.rbds_mode);
  assign exp_id     = next_id(last_id_r);
  assign fit_now    = (id_now == exp_id) ||
                      (exp_id == rds_sync_pkg::ID_C && id_now == rds_sync_pkg::ID_CP);
  assign fit_prev   = (id_prev == exp_id) ||
                      (exp_id == rds_sync_pkg::ID_C && id_prev == rds_sync_pkg::ID_CP);
  assign locked     = (phase_r == rds_sync_pkg::PH_LOCKED);
  assign boundary   = check_r && (bit_cnt_r == rds_sync_pkg::BLOCK_LAST_BIT);
  assign mode_limit = ({ctrl_r.search_correct_sel_hi, ctrl_r.search_correct_sel_lo}
                       == rds_sync_pkg::SEARCH_CORRECT_MODE_A) ? rds_sync_pkg::BURST_MODE_A :
                      ({ctrl_r.search_correct_sel_hi, ctrl_r.search_correct_sel_lo}
                       == rds_sync_pkg::SEARCH_CORRECT_MODE_B) ? rds_sync_pkg::BURST_MODE_B :
                      rds_sync_pkg::BURST_MODE_C;
  // burst trapping: syndrome confined to the low five bits gives the pattern
  assign t_top    = top_bit(t_r[4:0]);
  assign t_low    = low_bit(t_r[4:0]);
  assign t_span   = 3'(t_top - t_low + 3'h1);
  assign trapped  = (t_r[9:5] == 5'h00) && (t_span <= limit_r) &&
                    (({1'b0, pos_r} + {3'h0, t_top}) <= 6'h19);
  assign err_mask = {21'h0, t_r[4:0]} << pos_r;

  // ==========================================================================
  // alignment counter and evaluation engine
  always_ff @(posedge clock) begin
    res_stb_r <= 1'b0;
    if (sys_rst || ctrl_r.restart_sync_bit || phase_r == rds_sync_pkg::PH_HUNT) begin
      eng_r      <= rds_sync_pkg::EV_IDLE;
      bit_cnt_r  <= '0;
      res_ok_r   <= 1'b0;
      res_slot_r <= '0;
      work_r     <= '0;
      t_r        <= '0;
      pos_r      <= '0;
      limit_r    <= '0;
    end else begin
      if (check_r) begin
        bit_cnt_r <= boundary ? 5'h00 : 5'(bit_cnt_r + 5'h01);
      end
      case (eng_r)
        rds_sync_pkg::EV_IDLE: begin
          if (boundary) begin
            limit_r <= locked ? rds_sync_pkg::BURST_LOCKED : mode_limit;
            if (fit_now) begin
              res_stb_r  <= 1'b1;
              res_ok_r   <= 1'b1;
              res_slot_r <= '{sr_r[25:10], id_now, rds_sync_pkg::ST_CLEAN};
            end else if (locked && fit_prev) begin
              // block ended one bit early: realign by minus one
              res_stb_r  <= 1'b1;
              res_ok_r   <= 1'b1;
              res_slot_r <= '{sr_prev_r[25:10], id_prev, rds_sync_pkg::ST_CLEAN};
              bit_cnt_r  <= 5'h01;
            end else begin
              work_r <= sr_r;
              t_r    <= remainder(sr_r) ^ offset_of(exp_id);
              pos_r  <= '0;
              eng_r  <= locked ? rds_sync_pkg::EV_LATE : rds_sync_pkg::EV_CORR;
            end
          end
        end
        rds_sync_pkg::EV_LATE: begin
          if (check_r) begin
            if (fit_now) begin
              // block ended one bit late: realign by plus one
              res_stb_r  <= 1'b1;
              res_ok_r   <= 1'b1;
              res_slot_r <= '{sr_r[25:10], id_now, rds_sync_pkg::ST_CLEAN};
              bit_cnt_r  <= 5'h00;
              eng_r      <= rds_sync_pkg::EV_IDLE;
            end else begin
              eng_r <= rds_sync_pkg::EV_CORR;
            end
          end
        end
        rds_sync_pkg::EV_CORR: begin
          // one trial per clock, at most 26, well inside one block period
          if (trapped) begin
            res_stb_r  <= 1'b1;
            res_ok_r   <= 1'b1;
            res_slot_r <= '{work_r[25:10] ^ err_mask[25:10], exp_id,
                            rds_sync_pkg::ST_CORRECTED};
            eng_r      <= rds_sync_pkg::EV_IDLE;
          end else if (pos_r == rds_sync_pkg::BLOCK_LAST_BIT) begin
            res_stb_r  <= 1'b1;
            res_ok_r   <= 1'b0;
            res_slot_r <= '{work_r[25:10], exp_id, rds_sync_pkg::ST_UNCORR};
            eng_r      <= rds_sync_pkg::EV_IDLE;
          end else begin
            t_r   <= div_x(t_r);
            pos_r <= 5'(pos_r + 5'h01);
          end
        end
        default: eng_r <= rds_sync_pkg::EV_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // synchronisation state, flywheel and data-available events
  always_ff @(posedge clock) begin
    evt_blk_r    <= 1'b0;
    evt_dav_r    <= 1'b0;
    evt_locked_r <= 1'b0;
    if (sys_rst) begin
      phase_r    <= rds_sync_pkg::PH_HUNT;
      err_cnt_r  <= '0;
      last_id_r  <= rds_sync_pkg::ID_A;
      pair_r     <= 1'b0;
      evt_slot_r <= '0;
    end else if (ctrl_r.restart_sync_bit) begin
      phase_r   <= rds_sync_pkg::PH_HUNT;
      err_cnt_r <= '0;
    end else begin
      case (phase_r)
        rds_sync_pkg::PH_HUNT: begin
          // exact match only on every bit while hunting
          if (check_r && id_now != rds_sync_pkg::ID_NONE) begin
            evt_blk_r  <= 1'b1;
            evt_slot_r <= '{sr_r[25:10], id_now, rds_sync_pkg::ST_CLEAN};
            evt_dav_r  <= (ctrl_r.avail_mode == rds_sync_pkg::AVAIL_MODE_FAST_SEARCH) &&
                          (id_now == rds_sync_pkg::ID_A);
            if (id_now != rds_sync_pkg::ID_E_INVALID) begin
              phase_r   <= rds_sync_pkg::PH_SECOND;
              last_id_r <= id_now;
            end
          end
        end
        rds_sync_pkg::PH_SECOND: begin
          if (res_stb_r) begin
            evt_blk_r  <= 1'b1;
            evt_slot_r <= res_slot_r;
            if (res_ok_r) begin
              phase_r   <= rds_sync_pkg::PH_LOCKED;
              last_id_r <= res_slot_r.block_ident_field;
              err_cnt_r <= '0;
              pair_r    <= 1'b0;
              evt_dav_r <= 1'b1;
            end else begin
              phase_r <= rds_sync_pkg::PH_HUNT;
            end
          end
        end
        rds_sync_pkg::PH_LOCKED: begin
          if (res_stb_r) begin
            evt_blk_r    <= 1'b1;
            evt_locked_r <= 1'b1;
            evt_slot_r   <= res_slot_r;
            last_id_r    <= res_ok_r ? res_slot_r.block_ident_field : exp_id;
            pair_r       <= ~pair_r;
            evt_dav_r    <= (ctrl_r.avail_mode != rds_sync_pkg::AVAIL_MODE_REDUCED) ||
                            pair_r;
            if (res_ok_r) begin
              if (err_cnt_r != 6'h00) begin
                err_cnt_r <= 6'(err_cnt_r - 6'h01);
              end
            end else if (fly_max_r != rds_sync_pkg::FLY_OFF &&
                         fly_max_r != rds_sync_pkg::FLY_ENDLESS &&
                         err_cnt_r >= fly_max_r) begin
              phase_r   <= rds_sync_pkg::PH_HUNT;
              err_cnt_r <= '0;
              evt_dav_r <= 1'b1;
            end else if (fly_max_r != rds_sync_pkg::FLY_OFF &&
                         err_cnt_r != 6'h3f) begin
              err_cnt_r <= 6'(err_cnt_r + 6'h01);
            end
          end
        end
        default: phase_r <= rds_sync_pkg::PH_HUNT;
      endcase
    end
  end

  // ==========================================================================
  // output slots, data-available line and overflow
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_slot_r     <= '{16'h0000, rds_sync_pkg::ID_NONE, rds_sync_pkg::ST_CLEAN};
      prev_slot_r     <= '{16'h0000, rds_sync_pkg::ID_NONE, rds_sync_pkg::ST_CLEAN};
      overflow_flag_r <= 1'b0;
      data_ready_n_r  <= 1'b1;
      dav_cnt_r       <= '0;
    end else begin
      // a fresh overflow beats a status read in the same cycle
      if (evt_blk_r && evt_locked_r && !data_ready_n_r) begin
        overflow_flag_r <= 1'b1;
      end else if (rd_status) begin
        overflow_flag_r <= 1'b0;
      end
      // slots freeze while data is on offer or overflow stands
      if (evt_blk_r && data_ready_n_r && !overflow_flag_r) begin
        prev_slot_r <= last_slot_r;
        last_slot_r <= evt_slot_r;
      end
      if (evt_dav_r && data_ready_n_r && !overflow_flag_r) begin
        data_ready_n_r <= 1'b0;
        dav_cnt_r      <= '0;
      end else if (!data_ready_n_r) begin
        if (rd_last || dav_cnt_r == HOLD_W'(DAV_HOLD_CYC - 1)) begin
          data_ready_n_r <= 1'b1;
        end else begin
          dav_cnt_r <= HOLD_W'(dav_cnt_r + 1'b1);
        end
      end
    end
  end

  // ==========================================================================
  // ahb-lite slave: zero wait states, read data loaded at the address phase
  assign ap        = hsel && hready && htrans[1] && (hsize == rds_sync_pkg::HSIZE_WORD);
  assign rd_status = ap && !hwrite && (haddr[7:0] == rds_sync_pkg::STATUS_OFS);
  assign rd_last   = ap && !hwrite && (haddr[7:0] == rds_sync_pkg::LAST_OFS);

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      rds_sync_pkg::CTRL_OFS:   rd_word[5:0] = ctrl_r;
      rds_sync_pkg::FLY_OFS:    rd_word[5:0] = fly_max_r;
      rds_sync_pkg::STATUS_OFS: begin
        rd_word[rds_sync_pkg::STAT_SYNC_BIT]         = locked;
        rd_word[rds_sync_pkg::STAT_OVF_BIT]          = overflow_flag_r;
        rd_word[rds_sync_pkg::STAT_DAV_BIT]          = ~data_ready_n_r;
        rd_word[rds_sync_pkg::STAT_ERRCNT_LSB +: 6]  = err_cnt_r;
      end
      rds_sync_pkg::LAST_OFS:   rd_word[20:0] = last_slot_r;
      rds_sync_pkg::PREV_OFS:   rd_word[20:0] = prev_slot_r;
      default:                  rd_word = 32'h0000_0000;
    endcase
  end

  // bus phase tracking
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_pend_r   <= 1'b0;
      addr_r      <= '0;
      hrdata_r    <= '0;
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= 1'b1;
      wr_pend_r   <= ap && hwrite;
      hrdata_r    <= (ap && !hwrite) ? rd_word : 32'h0000_0000;
      if (ap) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  // control registers, written in the data phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_r    <= '0;
      fly_max_r <= rds_sync_pkg::FLY_MAX_RST;
    end else begin
      if (wr_pend_r && addr_r == rds_sync_pkg::CTRL_OFS) begin
        ctrl_r <= rds_sync_pkg::ctrl_t'(hwdata[5:0]);
      end else if (ctrl_r.restart_sync_bit) begin
        ctrl_r.restart_sync_bit <= 1'b0;
      end
      if (wr_pend_r && addr_r == rds_sync_pkg::FLY_OFS) begin
        fly_max_r <= hwdata[5:0];
      end
    end
  end

  assign hrdata       = hrdata_r;
  assign hreadyout    = hreadyout_r;
  assign hresp        = 1'b0;
  assign data_ready_n = data_ready_n_r;
endmodule
`default_nettype wire

// *** verif/rds_block_sync_decoder_props.sv ***
`default_nettype none
module rds_block_sync_decoder_props #(parameter int unsigned DAV_HOLD_CYC = 200) (
  // system
  input wire logic        clock,
  input wire logic        sys_rst,
  // bit link
  input wire logic        recovered_bit_clock,
  // bus
  input wire logic        hsel,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hrdata,
  input wire logic [1:0]  htrans,
  input wire logic [2:0]  hsize,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // handshake
  input wire logic        data_ready_n
);
  // ==========================================================================
  // read taken at the address phase; flops give data phase and low streak
  logic        tk, rd_r, bc_r;
  logic [7:0]  a_r, age_r;
  logic [31:0] low_r;
  assign tk = hsel & hready & htrans[1] & (hsize == 3'h2) & !hwrite;
  always_ff @(posedge clock) begin
    rd_r  <= tk & !sys_rst;
    a_r   <= haddr[7:0];
    bc_r  <= recovered_bit_clock;
    low_r <= (sys_rst | data_ready_n) ? 32'h0 : low_r + 32'h1;
  end
  // saturating age of the last raw bit clock rise, so it cannot wrap
  always_ff @(posedge clock) begin
    if (sys_rst) age_r <= 8'hff;
    else if (recovered_bit_clock & !bc_r) age_r <= 8'h0;
    else if (age_r != 8'hff) age_r <= age_r + 8'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_last_rd;
    tk && haddr[7:0] == rds_sync_pkg::LAST_OFS;
  endsequence
  AST_OKAY: assert property (!hresp) else $error("error response");
  AST_READY: assert property (hreadyout) else $error("wait state");
  AST_RD_ONLY: assert property (hrdata != 32'h0 |-> rd_r)
    else $error("stray read data");
  AST_UNMAP: assert property (rd_r && a_r > 8'h10 |-> hrdata == 32'h0)
    else $error("unmapped read data");
  AST_RELEASE: assert property (s_last_rd |-> ##[1:2] data_ready_n)
    else $error("ready not released");
  AST_HOLD: assert property (low_r <= DAV_HOLD_CYC + 1)
    else $error("ready held too long");
  AST_CAUSE: assert property ($fell(data_ready_n) |-> age_r < 8'h50)
    else $error("ready without bit");
  AST_RST: assert property ($fell(sys_rst) |-> data_ready_n && hrdata == 32'h0)
    else $error("outputs not idle");
endmodule
bind rds_block_sync_decoder rds_block_sync_decoder_props #(.DAV_HOLD_CYC(DAV_HOLD_CYC))
  i_rds_block_sync_decoder_props (.clock(clock), .sys_rst(sys_rst), .hsel(hsel),
  .recovered_bit_clock(recovered_bit_clock), .hwrite(hwrite), .hready(hready),
  .haddr(haddr), .hrdata(hrdata), .htrans(htrans), .hsize(hsize),
  .hreadyout(hreadyout), .hresp(hresp), .data_ready_n(data_ready_n));
`default_nettype wire

// *** verif/rds_bit_source.sv ***
`default_nettype none
module rds_bit_source (
  // recovered bit link
  output logic bclk,
  output logic bdat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [25:0] q[$];
  logic [25:0] w;
  // ==========================================================================
  // msb first, 320 ns a bit; clock parks low, data toggles while the queue is empty
  initial begin
    bclk = 1'b0;
    bdat = 1'b0;
    forever begin
      if (q.size() == 0) begin
        #160 bdat = ~bdat;
      end else begin
        w = q.pop_front();
        for (int i = 25; i >= 0; i--) begin
          bdat = w[i];
          #160 bclk = 1'b1;
          #160 bclk = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_rds_block_sync_decoder.sv ***
`default_nettype none
module tb_rds_block_sync_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // bench signals
  logic        clock, sys_rst, hsel, hwrite, hreadyout, hresp, data_ready_n, bclk, bdat;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          miscompares, checks_done;
  rds_block_sync_decoder #(.DAV_HOLD_CYC(200)) i_rds_block_sync_decoder (.clock(clock),
    .sys_rst(sys_rst), .recovered_bit_clock(bclk), .recovered_bit_data(bdat), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(rds_sync_pkg::HSIZE_WORD),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .data_ready_n(data_ready_n));
  rds_bit_source i_rds_bit_source (.bclk(bclk), .bdat(bdat));
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // block = info word, then remainder mod generator plus offset
  function automatic logic [25:0] enc(logic [15:0] d, logic [9:0] o);
    logic [25:0] r;
    r = {d, 10'h0};
    for (int i = 25; i >= 10; i--) if (r[i]) r[i-:11] ^= rds_sync_pkg::GEN_POLY;
    return {d, r[9:0] ^ o};
  endfunction
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one single ahb transfer; read data taken at the data phase edge
  task automatic bus(logic w, logic [7:0] a, logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task automatic dav();
    for (int n = 0; n < 3000 && data_ready_n !== 1'b0; n++) @(posedge clock);
    cmp("data_ready_n", 32'h0, {31'h0, data_ready_n});
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard, well past the five blocks
  initial begin
    repeat (8000) @(posedge clock);
    miscompares++;
    give_verdict();
  end
  // main sequence: reset, registers, then A B C(2 bit) D(6 bit burst) A
  initial begin
    {sys_rst, hsel, hwrite, htrans, haddr, hwdata, miscompares, checks_done} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    bus(1'b0, rds_sync_pkg::FLY_OFS, 32'h0);
    cmp("fly reset", 32'h20, rd); // flywheel default
    bus(1'b1, rds_sync_pkg::FLY_OFS, 32'h3f);
    bus(1'b0, rds_sync_pkg::FLY_OFS, 32'h0);
    cmp("fly max", 32'h3f, rd); // endless setting
    bus(1'b1, rds_sync_pkg::FLY_OFS, 32'h20);
    bus(1'b0, 8'h40, 32'h0);
    cmp("unmapped", 32'h0, rd); // reserved place
    i_rds_bit_source.q = '{enc(16'h1234, rds_sync_pkg::OFS_A), enc(16'habcd,
      rds_sync_pkg::OFS_B), enc(16'h5a5a, rds_sync_pkg::OFS_C) ^ 26'h3000,
      enc(16'h0f0f, rds_sync_pkg::OFS_D) ^ 26'hfc00, enc(16'h1111, rds_sync_pkg::OFS_A)};
    dav(); // lock offered
    bus(1'b0, rds_sync_pkg::PREV_OFS, 32'h0);
    cmp("prev", {11'h0, 16'h1234, rds_sync_pkg::ID_A, rds_sync_pkg::ST_CLEAN}, rd); // A
    bus(1'b0, rds_sync_pkg::LAST_OFS, 32'h0);
    cmp("last", {11'h0, 16'habcd, rds_sync_pkg::ID_B, rds_sync_pkg::ST_CLEAN}, rd); // B
    dav(); // per block
    bus(1'b0, rds_sync_pkg::LAST_OFS, 32'h0);
    cmp("fixed", {11'h0, 16'h5a5a, rds_sync_pkg::ID_C, rds_sync_pkg::ST_CORRECTED}, rd);
    dav(); // per block
    bus(1'b0, rds_sync_pkg::LAST_OFS, 32'h0);
    cmp("uncorr", {30'h0, rds_sync_pkg::ST_UNCORR}, {30'h0, rd[1:0]}); // burst over 5
    bus(1'b0, rds_sync_pkg::STATUS_OFS, 32'h0);
    cmp("status", 32'h9, rd); // synced, one error
    bus(1'b1, rds_sync_pkg::CTRL_OFS, 32'h1);
    bus(1'b0, rds_sync_pkg::STATUS_OFS, 32'h0);
    cmp("sync", 32'h0, {31'h0, rd[0]}); // restart drops lock
    bus(1'b0, rds_sync_pkg::CTRL_OFS, 32'h0);
    cmp("ctrl", 32'h0, rd); // restart bit self clears
    give_verdict();
  end
endmodule
`default_nettype wire
